/* logic/instr_decode_pkg.sv */
/*
  Constants and carrier types for the 12-bit instruction decoder.
  Assumes a single core clock and instruction words arriving with a valid strobe.
*/
// What this block does
// - Each instruction is one 12-bit word, opcode high, operands low.
// - Byte operations: opcode bits 11..6, destination bit 5, file bits 4..0.
// - Destination 0 writes accumulator, 1 writes back the addressed file register.
// - Bit operations: opcode bits 11..8, bit index 7..5, file bits 4..0.
// - Literal/control ops: opcode bits 11..8, immediate byte bits 7..0.
// - Absolute jump: opcode bits 11..9, nine-bit target bits 8..0.
// - One instruction cycle normally, two if test true or program counter changes.
// - One instruction cycle is exactly four core clock periods.
// - Don't-care operand bits never affect decoding; sources should fill zeros.
// - Five-bit file field selects one of 32 file registers.
package instr_decode_pkg;
  localparam int WORD_W = 12;
  localparam int FILE_W = 5;
  localparam int BIT_W = 3;
  localparam int LIT_W = 8;
  localparam int JUMP_W = 9;
  localparam int FILE_COUNT = 32;
  localparam int PHASES_PER_CYCLE = 4;
  localparam int DEST_POS = 5;
  localparam int BIT_LSB = 5;
  localparam int JUMP_OPC_LSB = 9;
  localparam logic [2:0] JUMP_OPC = 3'h5;
  localparam logic [2:0] JUMP_ALT = 3'h5;
  localparam logic [1:0] PHASE_LAST = 2'h3;
  localparam logic [1:0] PHASE_FIRST = 2'h0;

  typedef enum logic [1:0] {
    FMT_BYTE,
    FMT_BIT,
    FMT_LITERAL,
    FMT_JUMP
  } fmt_t;

  typedef enum logic {
    DEST_ACC,
    DEST_FILE
  } dest_t;

  typedef struct packed {
    fmt_t fmt;
    logic [5:0] opcode;
    dest_t dest;
    logic [FILE_W-1:0] file_addr;
    logic [BIT_W-1:0] bit_index;
    logic [JUMP_W-1:0] operand;
  } decoded_t;
endpackage

/* logic/instr_decoder.sv */
/*
  Twelve-bit instruction decoder with instruction-cycle sequencing.
  Assumes program memory presents a word with word_valid, and the core reports
  test or branch outcome during the cycle for the two-cycle cost.
*/
`timescale 1ns/1ps
module instr_decoder (
  // Clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // Instruction word from program memory
  input wire logic [instr_decode_pkg::WORD_W-1:0] instr_word,
  input wire logic word_valid,
  // Execution outcome from the core
  input wire logic test_true,
  input wire logic pc_changed,
  // Decoded fields, write flags and instruction-cycle status
  output instr_decode_pkg::decoded_t decoded_reg,
  output logic decoded_valid_reg,
  output logic [1:0] phase_reg,
  output logic cycle_end_reg,
  output logic second_cycle_reg,
  output logic acc_write_reg,
  output logic file_write_reg
);
  import instr_decode_pkg::*;

  decoded_t decoded_next;
  fmt_t fmt_next;
  logic busy_reg;
  logic accept;

  // Classify first, then pull fields; top bits alone pick the layout
  always_comb begin
    decoded_next = '0;
    if (instr_word[11:9] == JUMP_OPC) begin
      fmt_next = FMT_JUMP;
    end else if (instr_word[11:10] == 2'h1) begin
      fmt_next = FMT_BIT;
    end else if (instr_word[11:10] == 2'h0) begin
      fmt_next = FMT_BYTE;
    end else begin
      fmt_next = FMT_LITERAL;
    end
    decoded_next.fmt = fmt_next;
    unique case (fmt_next)
      FMT_BYTE: begin
        decoded_next.opcode = instr_word[11:6];
        decoded_next.dest = dest_t'(instr_word[DEST_POS]);
        decoded_next.file_addr = instr_word[FILE_W-1:0];
      end
      FMT_BIT: begin
        decoded_next.opcode = {2'h0, instr_word[11:8]};
        decoded_next.bit_index = instr_word[BIT_LSB+BIT_W-1:BIT_LSB];
        decoded_next.file_addr = instr_word[FILE_W-1:0];
      end
      FMT_LITERAL: begin
        decoded_next.opcode = {2'h0, instr_word[11:8]};
        decoded_next.operand = {1'b0, instr_word[LIT_W-1:0]};
      end
      FMT_JUMP: begin
        decoded_next.opcode = {3'h0, instr_word[11:JUMP_OPC_LSB]};
        decoded_next.operand = instr_word[JUMP_W-1:0];
      end
    endcase
  end

  // Off-phase words and words during a flush are dropped silently
  assign accept = word_valid && !busy_reg && phase_reg == PHASE_FIRST;

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      phase_reg <= PHASE_FIRST;
      cycle_end_reg <= 1'b0;
    end else begin
      phase_reg <= phase_reg + 2'h1;
      cycle_end_reg <= (phase_reg == 2'h2);
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      decoded_reg <= '0;
      decoded_valid_reg <= 1'b0;
      acc_write_reg <= 1'b0;
      file_write_reg <= 1'b0;
    end else if (accept) begin
      decoded_reg <= decoded_next;
      decoded_valid_reg <= 1'b1;
      acc_write_reg <= fmt_next == FMT_BYTE && decoded_next.dest == DEST_ACC;
      file_write_reg <= fmt_next == FMT_BYTE && decoded_next.dest == DEST_FILE;
    end else if (phase_reg == PHASE_LAST && !busy_reg) begin
      decoded_valid_reg <= 1'b0;
      acc_write_reg <= 1'b0;
      file_write_reg <= 1'b0;
    end
  end

  // Second instruction cycle is a flush; busy holds off the next fetch
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      busy_reg <= 1'b0;
      second_cycle_reg <= 1'b0;
    end else if (phase_reg == PHASE_LAST) begin
      if (busy_reg) begin
        busy_reg <= 1'b0;
        second_cycle_reg <= 1'b0;
      end else if (decoded_valid_reg && (test_true || pc_changed)) begin
        busy_reg <= 1'b1;
        second_cycle_reg <= 1'b1;
      end
    end
  end

  a_phase_wraps: assert property (@(posedge core_clk) disable iff (sys_rst)
    phase_reg == PHASE_LAST |=> phase_reg == PHASE_FIRST ##3 phase_reg == PHASE_LAST)
    else $error("Phase count is not four");
  a_cycle_end_pos: assert property (@(posedge core_clk) disable iff (sys_rst)
    cycle_end_reg |-> phase_reg == PHASE_LAST)
    else $error("Cycle end misplaced");
  a_two_cycle_cost: assert property (@(posedge core_clk) disable iff (sys_rst)
    phase_reg == PHASE_LAST && !busy_reg && decoded_valid_reg && pc_changed |=> second_cycle_reg [*4])
    else $error("Branch did not cost two cycles");
  a_one_cycle_cost: assert property (@(posedge core_clk) disable iff (sys_rst)
    phase_reg == PHASE_LAST && !busy_reg && !(decoded_valid_reg && (test_true || pc_changed)) |=> !second_cycle_reg)
    else $error("Plain instruction took two cycles");
  a_byte_fields: assert property (@(posedge core_clk) disable iff (sys_rst)
    accept && instr_word[11:10] == 2'h0 |=> decoded_reg.fmt == FMT_BYTE
      && decoded_reg.file_addr == $past(instr_word[4:0]) && decoded_reg.opcode == $past(instr_word[11:6]))
    else $error("Byte fields wrong");
  a_dest_select: assert property (@(posedge core_clk) disable iff (sys_rst)
    accept && instr_word[11:10] == 2'h0 |=> acc_write_reg == !$past(instr_word[5]) && file_write_reg != acc_write_reg)
    else $error("Destination select wrong");
  a_bit_fields: assert property (@(posedge core_clk) disable iff (sys_rst)
    accept && instr_word[11:10] == 2'h1 |=> decoded_reg.bit_index == $past(instr_word[7:5]))
    else $error("Bit index wrong");
  a_literal_fields: assert property (@(posedge core_clk) disable iff (sys_rst)
    accept && instr_word[11:10] != 2'h0 && instr_word[11:10] != 2'h1 && instr_word[11:9] != JUMP_OPC
      |=> decoded_reg.operand == {1'b0, $past(instr_word[7:0])} && decoded_reg.fmt == FMT_LITERAL)
    else $error("Literal fields wrong");
  a_jump_fields: assert property (@(posedge core_clk) disable iff (sys_rst)
    accept && instr_word[11:9] == JUMP_OPC |=> decoded_reg.operand == $past(instr_word[8:0]))
    else $error("Jump target wrong");
  a_no_fetch_busy: assert property (@(posedge core_clk) disable iff (sys_rst)
    busy_reg |=> $stable(decoded_reg))
    else $error("Fetch during flush cycle");
  c_branch: cover property (@(posedge core_clk) disable iff (sys_rst) second_cycle_reg);
  c_jump: cover property (@(posedge core_clk) disable iff (sys_rst) decoded_valid_reg && decoded_reg.fmt == FMT_JUMP);
  c_file_write: cover property (@(posedge core_clk) disable iff (sys_rst) file_write_reg);
  c_test_cost: cover property (@(posedge core_clk) disable iff (sys_rst)
    phase_reg == PHASE_LAST && !busy_reg && decoded_valid_reg && test_true);
  c_bit_format: cover property (@(posedge core_clk) disable iff (sys_rst)
    decoded_valid_reg && decoded_reg.fmt == FMT_BIT);

  // Unused fields read zero in every layout, so don't-care bits never leak out
  a_byte_unused: assert property (@(posedge core_clk) disable iff (sys_rst)
    accept && instr_word[11:10] == 2'h0 |=> decoded_reg.bit_index == 3'h0 && decoded_reg.operand == 9'h000)
    else $error("Byte layout shows unused fields");
  a_bit_unused: assert property (@(posedge core_clk) disable iff (sys_rst)
    accept && instr_word[11:10] == 2'h1 |=> decoded_reg.dest == DEST_ACC && decoded_reg.operand == 9'h000)
    else $error("Bit layout shows unused fields");
  a_literal_unused: assert property (@(posedge core_clk) disable iff (sys_rst)
    accept && instr_word[11:10] != 2'h0 && instr_word[11:10] != 2'h1 && instr_word[11:9] != JUMP_OPC
      |=> decoded_reg.file_addr == 5'h00 && decoded_reg.bit_index == 3'h0 && decoded_reg.dest == DEST_ACC)
    else $error("Literal layout shows unused fields");
  a_jump_unused: assert property (@(posedge core_clk) disable iff (sys_rst)
    accept && instr_word[11:9] == JUMP_OPC
      |=> decoded_reg.file_addr == 5'h00 && decoded_reg.bit_index == 3'h0 && decoded_reg.dest == DEST_ACC)
    else $error("Jump layout shows unused fields");

  // Opcode per layout, the shorter ones zero-extended
  a_bit_opcode: assert property (@(posedge core_clk) disable iff (sys_rst)
    accept && instr_word[11:10] == 2'h1 |=> decoded_reg.fmt == FMT_BIT
      && decoded_reg.opcode == {2'h0, $past(instr_word[11:8])} && decoded_reg.file_addr == $past(instr_word[4:0]))
    else $error("Bit opcode or file wrong");
  a_literal_opcode: assert property (@(posedge core_clk) disable iff (sys_rst)
    accept && instr_word[11:10] != 2'h0 && instr_word[11:10] != 2'h1 && instr_word[11:9] != JUMP_OPC
      |=> decoded_reg.opcode == {2'h0, $past(instr_word[11:8])})
    else $error("Literal opcode wrong");
  a_jump_opcode: assert property (@(posedge core_clk) disable iff (sys_rst)
    accept && instr_word[11:9] == JUMP_OPC |=> decoded_reg.fmt == FMT_JUMP
      && decoded_reg.opcode == {3'h0, $past(instr_word[11:9])})
    else $error("Jump opcode wrong");

  // One answer per accepted word; fields frozen otherwise
  a_answer_next: assert property (@(posedge core_clk) disable iff (sys_rst)
    accept |=> decoded_valid_reg)
    else $error("No answer after accept");
  a_hold_fields: assert property (@(posedge core_clk) disable iff (sys_rst)
    !accept |=> $stable(decoded_reg))
    else $error("Fields changed without a new word");
  a_valid_drop: assert property (@(posedge core_clk) disable iff (sys_rst)
    phase_reg == PHASE_LAST |=> !decoded_valid_reg && !acc_write_reg && !file_write_reg)
    else $error("Flags outlived their cycle");
  a_write_byte_only: assert property (@(posedge core_clk) disable iff (sys_rst)
    acc_write_reg || file_write_reg |-> decoded_valid_reg && decoded_reg.fmt == FMT_BYTE
      && file_write_reg == (decoded_reg.dest == DEST_FILE) && acc_write_reg != file_write_reg)
    else $error("Write flag without a byte operation");

  // Flush cycle and phase bookkeeping
  a_test_cost: assert property (@(posedge core_clk) disable iff (sys_rst)
    phase_reg == PHASE_LAST && !busy_reg && decoded_valid_reg && test_true |=> second_cycle_reg [*4])
    else $error("True test did not cost two cycles");
  a_flush_no_valid: assert property (@(posedge core_clk) disable iff (sys_rst)
    second_cycle_reg |-> !decoded_valid_reg)
    else $error("Valid fields during flush");
  a_flush_ends: assert property (@(posedge core_clk) disable iff (sys_rst)
    second_cycle_reg && phase_reg == PHASE_LAST |=> !second_cycle_reg)
    else $error("Flush ran past one cycle");
  a_phase_steps: assert property (@(posedge core_clk) disable iff (sys_rst)
    phase_reg != PHASE_LAST |=> phase_reg == $past(phase_reg) + 2'h1)
    else $error("Phase skipped a step");
  a_cycle_end_rise: assert property (@(posedge core_clk) disable iff (sys_rst)
    phase_reg == 2'h2 |=> cycle_end_reg)
    else $error("Cycle end missing");

  // Saturating count of clocks since the last accept; accepts land on whole cycles only
  logic [3:0] since_accept_reg;
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      since_accept_reg <= 4'h0;
    end else if (accept) begin
      since_accept_reg <= 4'h1;
    end else if (since_accept_reg != 4'h0 && since_accept_reg != 4'hf) begin
      since_accept_reg <= since_accept_reg + 4'h1;
    end
  end
  a_accept_spacing: assert property (@(posedge core_clk) disable iff (sys_rst)
    accept && since_accept_reg != 4'h0 && since_accept_reg != 4'hf |-> since_accept_reg[1:0] == 2'h0)
    else $error("Word accepted off the cycle boundary");
endmodule

/* tb/prog_mem.sv */
/*
  Program memory model feeding instruction words to the decoder.
  Assumes the bench asks for a word and holds the request until it is taken.
*/
`timescale 1ns/1ps
module prog_mem (
  // Clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // Request from the bench
  input wire logic fetch_req,
  input wire logic [instr_decode_pkg::WORD_W-1:0] fetch_word,
  // Word toward the decoder
  output logic [instr_decode_pkg::WORD_W-1:0] instr_word,
  output logic word_valid
);
  import instr_decode_pkg::*;
  logic [WORD_W-1:0] last_reg;
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      last_reg <= 12'h000;
    end else if (fetch_req) begin
      last_reg <= fetch_word;
    end
  end
  // Idle bus shows the inverted last word, so stale data never passes
  assign word_valid = fetch_req;
  assign instr_word = fetch_req ? fetch_word : ~last_reg;
endmodule

/* tb/instr_decoder_bench.sv */
/*
  Scenario bench for the instruction decoder, the bench playing the core.
  Assumes prog_mem supplies words; unused decoded fields read as zero.
*/
`timescale 1ns/1ps
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin fail_count++; $display("unexpected %0t bad value", $time); end end
module instr_decoder_bench;
  import instr_decode_pkg::*;
  logic core_clk = 0;
  logic sys_rst = 1;
  logic req = 0;
  logic [11:0] wd = 12'h000;
  logic test_true = 0;
  logic pc_changed = 0;
  logic [11:0] instr_word;
  logic word_valid, dv, ce, sc, aw, fw;
  logic [1:0] ph;
  decoded_t dec;
  int fail_count = 0;
  int checks_done = 0;
  int n;
  always #2 core_clk = ~core_clk;
  prog_mem mem_u (.core_clk(core_clk), .sys_rst(sys_rst), .fetch_req(req), .fetch_word(wd),
    .instr_word(instr_word), .word_valid(word_valid));
  instr_decoder dut_u (.core_clk(core_clk), .sys_rst(sys_rst), .instr_word(instr_word),
    .word_valid(word_valid), .test_true(test_true), .pc_changed(pc_changed), .decoded_reg(dec),
    .decoded_valid_reg(dv), .phase_reg(ph), .cycle_end_reg(ce), .second_cycle_reg(sc),
    .acc_write_reg(aw), .file_write_reg(fw));
  task results;
    $display("checks %0d errors %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // Word is offered at the edge that starts phase 0, dropped two edges later, read at the next falling edge
  task issue(input logic [11:0] w);
    do @(negedge core_clk); while (ph !== 2'h3);
    @(posedge core_clk) begin req <= 1; wd <= w; end
    @(posedge core_clk);
    @(posedge core_clk) req <= 0;
    @(negedge core_clk);
  endtask
  task t_byte;
    issue(12'h1c0);
    `CHK(dec, decoded_t'{FMT_BYTE, 6'h07, DEST_ACC, 5'h00, 3'h0, 9'h000})
    `CHK({dv, aw, fw}, 3'h6)
    issue(12'h03f);
    `CHK(dec, decoded_t'{FMT_BYTE, 6'h00, DEST_FILE, 5'h1f, 3'h0, 9'h000})
    `CHK({aw, fw}, 2'h1)
  endtask
  task t_formats;
    issue(12'h5e3);
    `CHK(dec, decoded_t'{FMT_BIT, 6'h05, DEST_ACC, 5'h03, 3'h7, 9'h000})
    `CHK({aw, fw}, 2'h0)
    issue(12'hca5);
    `CHK(dec, decoded_t'{FMT_LITERAL, 6'h0c, DEST_ACC, 5'h00, 3'h0, 9'h0a5})
    issue(12'h9a5);
    `CHK(dec, decoded_t'{FMT_LITERAL, 6'h09, DEST_ACC, 5'h00, 3'h0, 9'h0a5})
    issue(12'hbff);
    `CHK(dec, decoded_t'{FMT_JUMP, 6'h05, DEST_ACC, 5'h00, 3'h0, 9'h1ff})
  endtask
  task t_cycles;
    n = 0;
    repeat (16) @(negedge core_clk) n += ce;
    `CHK(n, 4)
    for (int s = 0; s < 2; s++) begin
      issue(12'hbff);
      @(posedge core_clk) begin req <= 1; wd <= 12'h07f; test_true <= (s == 0); pc_changed <= (s == 1); end
      @(posedge core_clk) begin test_true <= 0; pc_changed <= 0; end
      n = 0;
      repeat (4) @(negedge core_clk) n += sc;
      `CHK(n, 4)
      `CHK(dec.fmt, FMT_JUMP)
      // Flush ends at the next edge; the held word is taken at the one after
      repeat (2) @(posedge core_clk);
      req <= 0;
      @(negedge core_clk);
      `CHK({dec.fmt, sc}, {FMT_BYTE, 1'b0})
    end
  endtask
  initial begin
    repeat (10) @(posedge core_clk);
    sys_rst <= 0;
    t_byte();
    t_formats();
    t_cycles();
    results();
  end
  initial begin
    #20000;
    fail_count++;
    results();
  end
endmodule
